// *** dv/desc_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module desc_mem_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire dma_fetch_pkg::mem_cmd_t mem_cmd,
  input wire logic [1:0] lat,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  // Word store; descriptors sit in ascending words, list entries contiguous
  logic [31:0] mem [0:4095];
  logic [1:0] wait_q;
  logic hit;

  ////////////////////////////////////////////////////////////////////////////
  // A request is answered once it has waited lat cycles
  assign hit = mem_cmd.req && !mem_ack && (wait_q == lat);

  // One-cycle acknowledge pulse per request, one request at a time
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mem_ack <= 1'b0;
      wait_q <= 2'h0;
    end else if (hit) begin
      mem_ack <= 1'b1;
      wait_q <= 2'h0;
    end else begin
      mem_ack <= 1'b0;
      if (mem_cmd.req && !mem_ack) wait_q <= wait_q + 2'h1;
    end
  end

  // Write lands at the ack; plain always so the bench may preload words
  always @(posedge mclk) begin
    if (rst_n && hit && mem_cmd.we) mem[mem_cmd.addr[13:2]] <= mem_cmd.wdata;
  end

  // Read data is only meaningful in the ack cycle; it churns otherwise
  always_ff @(posedge mclk) begin
    if (!rst_n) mem_rdata <= 32'h5a5a_a5a5;
    else if (hit) mem_rdata <= mem[mem_cmd.addr[13:2]];
    else mem_rdata <= ~mem_rdata;
  end
endmodule
`default_nettype wire

// *** dv/tx_descriptor_dma_fetch_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tx_descriptor_dma_fetch_tb_top;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  dma_fetch_pkg::mem_cmd_t mem_cmd;
  logic mem_ack;
  logic [31:0] mem_rdata;
  dma_fetch_pkg::tx_beat_t tx_beat;
  dma_fetch_pkg::tx_beat_t exp_q[$];
  dma_fetch_pkg::tx_beat_t seen_q[$];
  logic tx_valid;
  logic tx_ready = 1'b0;
  logic stall = 1'b0;
  logic [1:0] lat = 2'h0;
  int n_errors = 0;
  int checks_done = 0;
  logic [27:0] tx_st = 28'h800_0105;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and instances
  always #10 mclk = ~mclk;

  tx_descriptor_dma_fetch i_tx_descriptor_dma_fetch (.mclk(mclk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_cmd(mem_cmd), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .tx_beat(tx_beat), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_status(tx_st));

  desc_mem_model i_mem (.mclk(mclk), .rst_n(rst_n), .mem_cmd(mem_cmd), .lat(lat),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  // Sink stalls every other cycle when asked to
  always @(posedge mclk) tx_ready <= stall ? ~tx_ready : 1'b1;

  // Collect every beat taken by the sink
  always @(posedge mclk) begin
    if (rst_n && tx_valid && tx_ready) seen_q.push_back(tx_beat);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare, report and close
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_errors++;
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic e;
    apb(1'b0, a, 32'h0000_0000, d, e);
  endtask

  // Build one descriptor and its buffer, queue the beats it should produce
  task automatic add_desc(input logic [31:0] da, input logic [31:0] ba, input logic [1:0] fp,
                          input logic le, input logic [15:0] nb);
    logic [31:0] w;
    int k;
    int nw;
    nw = (nb + 3) / 4;
    for (k = 0; k < nw; k++) begin
      w = {ba[15:0], 16'(k)} ^ 32'hc3a5_0000;
      i_mem.mem[12'((ba >> 2) + k)] = w;
      exp_q.push_back({w, (k < nw - 1 || nb[1:0] == 2'h0) ? 4'hf : 4'((1 << nb[1:0]) - 1),
                       (k == 0) & fp[1], (k == nw - 1) & fp[0]});
    end
    i_mem.mem[da[13:2]] = {1'b1, le, fp, 28'h000_0000};
    i_mem.mem[da[13:2] + 12'h001] = {nb, 16'h0000};
    i_mem.mem[da[13:2] + 12'h002] = ba;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [31:0] v;
    logic e;
    logic [31:0] base;
    logic [31:0] dl;
    logic [1:0] fps [4];
    logic [15:0] lens [4];
    int n;
    fps = '{2'h3, 2'h2, 2'h0, 2'h1};
    lens = '{16'h0006, 16'h0004, 16'h0001, 16'h0003};
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    rd(dma_fetch_pkg::OFS_MODE, v);
    check("mode reset", v, 64'(dma_fetch_pkg::MODE_RST));
    rd(dma_fetch_pkg::OFS_BASE, v);
    check("base reset", v, 64'(dma_fetch_pkg::BASE_RST));
    rd(dma_fetch_pkg::OFS_TREQ, v);
    check("request reset", v, 64'h0);
    apb(1'b1, 8'h14, 32'hffff_ffff, v, e);
    check("unmapped write err", e, 64'h1);
    apb(1'b0, 8'h14, 32'h0000_0000, v, e);
    check("unmapped read err", {v, 31'h0, e}, 64'h1);
    wr(dma_fetch_pkg::OFS_STAT, 32'hffff_ffff);
    rd(dma_fetch_pkg::OFS_STAT, v);
    check("status read only", v, 64'h0);
    for (int m = 0; m < 4; m++) begin
      dl = (m == 1) ? 32'h0000_0020 : (m == 2) ? 32'h0000_0040 : 32'h0000_0010;
      base = 32'(m) * 32'h0000_0800;
      lat <= 2'(m);
      tx_st <= 28'h800_0105 ^ 28'(m);
      stall <= m[0];
      wr(dma_fetch_pkg::OFS_MODE, 32'(m));
      wr(dma_fetch_pkg::OFS_BASE, base);
      for (int i = 0; i < 4; i++) begin
        add_desc(base + 32'(i) * dl, base + 32'h0000_0400 + 32'(i) * 32'h0000_0020, fps[i],
                 i == 3, lens[i]);
      end
      wr(dma_fetch_pkg::OFS_TREQ, 32'h0000_0001);
      n = 0;
      v = 32'h0000_0001;
      while (v[0] !== 1'b0 && n < 200) begin
        rd(dma_fetch_pkg::OFS_TREQ, v);
        n++;
      end
      if (n >= 200) begin
        n_errors++;
        complete_run();
      end
      rd(dma_fetch_pkg::OFS_FETCH, v);
      check("fetch after wrap", v, 64'(base));
      rd(dma_fetch_pkg::OFS_STAT, v);
      check("halted", v[3], 64'h1);
      for (int i = 0; i < 4; i++) begin
        v = i_mem.mem[12'((base + 32'(i) * dl) >> 2)];
        check("write back", v, {33'h0, i == 3, fps[i], fps[i][0] ? tx_st : 28'h0});
      end
      check("beat count", seen_q.size(), exp_q.size());
      for (int i = 0; i < exp_q.size(); i++) begin
        check("beat", 64'(seen_q[i]), 64'(exp_q[i]));
      end
      seen_q.delete();
      exp_q.delete();
    end
    complete_run();
  end
endmodule
`default_nettype wire

// *** logic/desc_word_store.sv ***
`timescale 1ns/1ps
`default_nettype none
module desc_word_store (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [1:0] wr_idx,
  input wire logic [31:0] wr_data,
  output logic [31:0] ctl_word,
  output logic [31:0] len_word,
  output logic [31:0] buf_word
);

  logic [31:0] word_q [3];

  // One register per fetched descriptor word
  genvar gi;
  for (gi = 0; gi < 3; gi++) begin : g_word
    always_ff @(posedge mclk) begin
      if (!rst_n) begin
        word_q[gi] <= 32'h0000_0000;
      end else if (wr_en && wr_idx == 2'(gi)) begin
        word_q[gi] <= wr_data;
      end
    end
  end

  assign ctl_word = word_q[0];
  assign len_word = word_q[1];
  assign buf_word = word_q[2];

endmodule
`default_nettype wire

// *** logic/tx_descriptor_dma_fetch.sv ***
`timescale 1ns/1ps
`default_nettype none
// Function
// R1: Descriptor is control, length, buffer address words, then padding, ascending.
// R2: Padding sized so descriptor spans the selected descriptor length.
// R3: Whole third word is the transmit buffer start address.
// R4: Upper half of second word is the byte count to move.
// R5: Frames use one descriptor or several concatenated descriptors.
// R6: Software prepares descriptors before setting the transmit request bit.
// R7: After a descriptor's data, write back control word with status, valid cleared.
// R8: Software writes only bits 31 to 28 of the control word, rest zero.
// R9: Software fills the buffer before setting the valid flag.
// R10: Engine clears the valid flag after moving the descriptor's data.
// R11: Invalid fetched descriptor clears the request bit and halts the engine.
// R12: Engine keeps going while the next fetched descriptor is valid.
// R13: List end clear: next descriptor follows contiguously.
// R14: List end set: next descriptor comes from the list base address.
// R15: Position code 00 middle, 01 end, 10 start.
// R16: Position code 11 means the descriptor holds the whole frame.
// R17: Software codes split frames start, middles, end.
// R18: Setting the transmit request bit starts descriptor fetching.
// R19: List descriptors are contiguous, spaced by the selected length.
// R20: Software supplies word-aligned buffer addresses.
module tx_descriptor_dma_fetch (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output dma_fetch_pkg::mem_cmd_t mem_cmd,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output dma_fetch_pkg::tx_beat_t tx_beat,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic [27:0] tx_status
);

  dma_fetch_pkg::state_t state_q;
  dma_fetch_pkg::mem_cmd_t mem_q;
  dma_fetch_pkg::tx_beat_t beat_q;
  logic [1:0] mode_q, fp, store_idx;
  logic [31:0] base_q, cur_q, buf_ptr_q, prdata_q, ctl_w, len_w, buf_w;
  logic [31:0] issue_addr, wb_word, desc_len, rd_val;
  logic [15:0] rem_q, take;
  logic [3:0] keep_d;
  logic tx_valid_q, treq_q, halted_q, first_q, pready_q, pslverr_q;
  logic acc, issue, issue_we, fp_has_end, fp_has_start, apb_wr, rd_hit, store_en;

  ////////////////////////////////////////////////////////////////////////////
  // APB register access

  // Completing edge of an APB write transfer
  assign apb_wr = psel && penable && pready_q && pwrite;

  // Read mux and address decode
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    if (paddr == dma_fetch_pkg::OFS_MODE) begin
      rd_val = {30'h0000_0000, mode_q};
    end else if (paddr == dma_fetch_pkg::OFS_TREQ) begin
      rd_val = {31'h0000_0000, treq_q};
    end else if (paddr == dma_fetch_pkg::OFS_BASE) begin
      rd_val = base_q;
    end else if (paddr == dma_fetch_pkg::OFS_FETCH) begin
      rd_val = cur_q;
    end else if (paddr == dma_fetch_pkg::OFS_STAT) begin
      rd_val = {26'h000_0000, fp, halted_q, state_q};
    end else begin
      rd_hit = 1'b0;
    end
  end

  // One wait state, then pready with data and error
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !rd_hit;
      prdata_q <= (psel && penable && !pready_q && !pwrite && rd_hit) ? rd_val : 32'h0000_0000;
    end
  end

  // Mode and list base registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mode_q <= dma_fetch_pkg::MODE_RST;
      base_q <= dma_fetch_pkg::BASE_RST;
    end else if (apb_wr && paddr == dma_fetch_pkg::OFS_MODE) begin
      mode_q <= pwdata[1:0];
    end else if (apb_wr && paddr == dma_fetch_pkg::OFS_BASE) begin
      base_q <= pwdata;
    end
  end

  // Transmit request bit: software sets, engine clears on halt, set wins
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      treq_q <= 1'b0;
      halted_q <= 1'b0;
    end else if (apb_wr && paddr == dma_fetch_pkg::OFS_TREQ && pwdata[0]) begin
      treq_q <= 1'b1; // R18
      halted_q <= 1'b0;
    end else if (state_q == dma_fetch_pkg::ST_RD_CTL && acc
                 && !mem_rdata[dma_fetch_pkg::VALID_BIT]) begin
      treq_q <= 1'b0; // R11
      halted_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Descriptor decode

  // Descriptor spacing from the length selection
  always_comb begin
    case (mode_q)
      2'h0: desc_len = dma_fetch_pkg::DESC_LEN_SEL0; // R2
      2'h1: desc_len = dma_fetch_pkg::DESC_LEN_SEL1;
      2'h2: desc_len = dma_fetch_pkg::DESC_LEN_SEL2;
      default: desc_len = dma_fetch_pkg::DESC_LEN_SEL3;
    endcase
  end

  // Frame position code of the held descriptor
  assign fp = ctl_w[dma_fetch_pkg::FP_HI_BIT:dma_fetch_pkg::FP_LO_BIT]; // R15
  assign fp_has_end = (fp == dma_fetch_pkg::FP_END) || (fp == dma_fetch_pkg::FP_WHOLE); // R16
  assign fp_has_start = (fp == dma_fetch_pkg::FP_START) || (fp == dma_fetch_pkg::FP_WHOLE); // R16

  // Write-back word: valid cleared, status only on the frame's last descriptor
  assign wb_word = {1'b0, ctl_w[dma_fetch_pkg::LIST_END_BIT], fp,
                    fp_has_end ? tx_status : 28'h000_0000}; // R7 R10

  // Byte count of the next data word and its lane mask
  assign take = (rem_q >= 16'h0004) ? 16'h0004 : rem_q;
  always_comb begin
    case (take)
      16'h0001: keep_d = 4'h1;
      16'h0002: keep_d = 4'h3;
      16'h0003: keep_d = 4'h7;
      default: keep_d = 4'hF;
    endcase
  end

  // Fetched words go to the small store
  assign store_en = acc && (state_q == dma_fetch_pkg::ST_RD_CTL
                            || state_q == dma_fetch_pkg::ST_RD_LEN
                            || state_q == dma_fetch_pkg::ST_RD_BUF);
  assign store_idx = (state_q == dma_fetch_pkg::ST_RD_CTL) ? 2'h0 :
                     (state_q == dma_fetch_pkg::ST_RD_LEN) ? 2'h1 : 2'h2;

  desc_word_store u_store (
    .mclk(mclk),
    .rst_n(rst_n),
    .wr_en(store_en),
    .wr_idx(store_idx),
    .wr_data(mem_rdata),
    .ctl_word(ctl_w),
    .len_word(len_w),
    .buf_word(buf_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Memory master

  assign acc = mem_q.req && mem_ack;

  // Request selection per state
  always_comb begin
    issue = 1'b0;
    issue_we = 1'b0;
    issue_addr = cur_q;
    case (state_q)
      dma_fetch_pkg::ST_RD_CTL: begin
        issue = 1'b1;
        issue_addr = cur_q + dma_fetch_pkg::WOFS_CTL; // R1
      end
      dma_fetch_pkg::ST_RD_LEN: begin
        issue = 1'b1;
        issue_addr = cur_q + dma_fetch_pkg::WOFS_LEN; // R1
      end
      dma_fetch_pkg::ST_RD_BUF: begin
        issue = 1'b1;
        issue_addr = cur_q + dma_fetch_pkg::WOFS_BUF; // R1
      end
      dma_fetch_pkg::ST_MOVE: begin
        issue = (rem_q != 16'h0000) && !tx_valid_q;
        issue_addr = buf_ptr_q;
      end
      dma_fetch_pkg::ST_WBACK: begin
        issue = 1'b1;
        issue_we = 1'b1;
      end
      default: issue = 1'b0;
    endcase
    if (mem_q.req) begin
      issue = 1'b0;
    end
  end

  // One request outstanding, held until acknowledged
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mem_q <= '0;
    end else if (acc) begin
      mem_q.req <= 1'b0;
    end else if (issue) begin
      mem_q.req <= 1'b1;
      mem_q.we <= issue_we;
      mem_q.addr <= issue_addr;
      mem_q.wdata <= issue_we ? wb_word : 32'h0000_0000; // R7
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Descriptor sequencer

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_q <= dma_fetch_pkg::ST_IDLE;
    end else begin
      case (state_q)
        dma_fetch_pkg::ST_IDLE: if (treq_q) state_q <= dma_fetch_pkg::ST_RD_CTL; // R18
        dma_fetch_pkg::ST_RD_CTL: begin
          if (acc && !mem_rdata[dma_fetch_pkg::VALID_BIT]) begin
            state_q <= dma_fetch_pkg::ST_IDLE; // R11
          end else if (acc) begin
            state_q <= dma_fetch_pkg::ST_RD_LEN;
          end
        end
        dma_fetch_pkg::ST_RD_LEN: if (acc) state_q <= dma_fetch_pkg::ST_RD_BUF;
        dma_fetch_pkg::ST_RD_BUF: if (acc) state_q <= dma_fetch_pkg::ST_MOVE;
        dma_fetch_pkg::ST_MOVE: begin
          if (rem_q == 16'h0000 && !tx_valid_q && !mem_q.req) begin
            state_q <= dma_fetch_pkg::ST_WBACK;
          end
        end
        dma_fetch_pkg::ST_WBACK: if (acc) state_q <= dma_fetch_pkg::ST_RD_CTL; // R12
        default: state_q <= dma_fetch_pkg::ST_IDLE;
      endcase
    end
  end

  // Current descriptor address; a halt keeps it so a restart refetches
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cur_q <= dma_fetch_pkg::BASE_RST;
    end else if (apb_wr && paddr == dma_fetch_pkg::OFS_BASE
                 && state_q == dma_fetch_pkg::ST_IDLE) begin
      cur_q <= pwdata;
    end else if (state_q == dma_fetch_pkg::ST_WBACK && acc) begin
      if (ctl_w[dma_fetch_pkg::LIST_END_BIT]) begin
        cur_q <= base_q; // R14
      end else begin
        cur_q <= cur_q + desc_len; // R13 R19
      end
    end
  end

  // Buffer pointer and remaining byte count
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      buf_ptr_q <= 32'h0000_0000;
      rem_q <= 16'h0000;
      first_q <= 1'b0;
    end else if (state_q == dma_fetch_pkg::ST_RD_BUF && acc) begin
      buf_ptr_q <= mem_rdata; // R3
      rem_q <= len_w[dma_fetch_pkg::LEN_HI_BIT:dma_fetch_pkg::LEN_LO_BIT]; // R4
      first_q <= 1'b1;
    end else if (state_q == dma_fetch_pkg::ST_MOVE && acc) begin
      buf_ptr_q <= buf_ptr_q + dma_fetch_pkg::WORD_BYTES; // R20
      rem_q <= rem_q - take;
      first_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit data stream toward the FIFO

  // Buffers chain into one frame: start marks only the first, end the last
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      beat_q <= '0;
      tx_valid_q <= 1'b0;
    end else if (state_q == dma_fetch_pkg::ST_MOVE && acc) begin
      tx_valid_q <= 1'b1;
      beat_q.data <= mem_rdata;
      beat_q.keep <= keep_d;
      beat_q.sof <= first_q && fp_has_start; // R5 R17
      beat_q.eof <= (rem_q <= 16'h0004) && fp_has_end; // R5 R15
    end else if (tx_valid_q && tx_ready) begin
      tx_valid_q <= 1'b0;
    end
  end

  assign mem_cmd = mem_q;
  assign tx_beat = beat_q;
  assign tx_valid = tx_valid_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  chk_halt_invalid: assert property ( // R11
    (state_q == dma_fetch_pkg::ST_RD_CTL && acc && !mem_rdata[31]
     && !(apb_wr && paddr == dma_fetch_pkg::OFS_TREQ))
    |=> !treq_q && halted_q && state_q == dma_fetch_pkg::ST_IDLE)
    else $error("invalid descriptor did not halt the engine");
  chk_list_wrap: assert property ( // R14
    (state_q == dma_fetch_pkg::ST_WBACK && acc && ctl_w[30]) |=> cur_q == $past(base_q))
    else $error("list end did not wrap to base");
  chk_list_next: assert property ( // R13
    (state_q == dma_fetch_pkg::ST_WBACK && acc && !ctl_w[30])
    |=> cur_q == $past(cur_q) + $past(desc_len))
    else $error("next descriptor not contiguous");
  chk_wb_valid: assert property ( // R10
    (mem_q.req && mem_q.we) |-> !mem_q.wdata[31] && mem_q.addr == cur_q)
    else $error("write-back left valid set or hit wrong address");
  chk_len_taken: assert property ( // R4
    (state_q == dma_fetch_pkg::ST_RD_BUF && acc)
    |=> rem_q == $past(len_w[31:16]) && buf_ptr_q == $past(mem_rdata))
    else $error("length or buffer address not taken");
  chk_buf_read: assert property ( // R3
    (state_q == dma_fetch_pkg::ST_MOVE && $rose(mem_q.req) && first_q)
    |-> mem_q.addr == buf_w && !mem_q.we)
    else $error("first data read not at buffer start");
  chk_start_fetch: assert property ( // R18
    (state_q == dma_fetch_pkg::ST_IDLE && treq_q && !mem_q.req)
    |=> ##1 mem_q.req && mem_q.addr == cur_q && !mem_q.we)
    else $error("request bit did not start a fetch");
  chk_wb_status: assert property ( // R7
    (mem_q.req && mem_q.we && mem_q.wdata[28])
    |-> mem_q.wdata[27:0] == $past(tx_status) || $past(mem_q.req))
    else $error("end descriptor status not written back");
  chk_continue: assert property ( // R12
    (state_q == dma_fetch_pkg::ST_WBACK && acc)
    |=> state_q == dma_fetch_pkg::ST_RD_CTL ##1 mem_q.req)
    else $error("engine did not fetch the next descriptor");
  chk_eof_code: assert property ( // R15
    (tx_valid_q && beat_q.eof) |-> ctl_w[28])
    else $error("frame end on a start or middle descriptor");

  cov_halt: cover property (halted_q && $rose(halted_q));
  cov_wrap: cover property (state_q == dma_fetch_pkg::ST_WBACK && acc && ctl_w[30]);
  cov_multi: cover property (tx_valid_q && tx_ready && beat_q.eof && fp == dma_fetch_pkg::FP_END);

endmodule
`default_nettype wire

// *** pkg/dma_fetch_pkg.sv ***
`default_nettype none
package dma_fetch_pkg;

  // Register byte offsets on the APB side
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_TREQ = 8'h04;
  localparam logic [7:0] OFS_BASE = 8'h08;
  localparam logic [7:0] OFS_FETCH = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;

  // Reset values
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [31:0] BASE_RST = 32'h0000_0000;

  // Descriptor word offsets inside one descriptor
  localparam logic [31:0] WOFS_CTL = 32'h0000_0000;
  localparam logic [31:0] WOFS_LEN = 32'h0000_0004;
  localparam logic [31:0] WOFS_BUF = 32'h0000_0008;
  localparam logic [31:0] WORD_BYTES = 32'h0000_0004;

  // Descriptor length per length selection code, in bytes
  localparam logic [31:0] DESC_LEN_SEL0 = 32'h0000_0010;
  localparam logic [31:0] DESC_LEN_SEL1 = 32'h0000_0020;
  localparam logic [31:0] DESC_LEN_SEL2 = 32'h0000_0040;
  localparam logic [31:0] DESC_LEN_SEL3 = 32'h0000_0010;

  // Field positions in the control and length words
  localparam int VALID_BIT = 31;
  localparam int LIST_END_BIT = 30;
  localparam int FP_HI_BIT = 29;
  localparam int FP_LO_BIT = 28;
  localparam int LEN_HI_BIT = 31;
  localparam int LEN_LO_BIT = 16;
  localparam int STATUS_W = 28;

  // Frame position codes
  localparam logic [1:0] FP_MIDDLE = 2'h0;
  localparam logic [1:0] FP_END = 2'h1;
  localparam logic [1:0] FP_START = 2'h2;
  localparam logic [1:0] FP_WHOLE = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RD_CTL = 3'h1,
    ST_RD_LEN = 3'h3,
    ST_RD_BUF = 3'h2,
    ST_MOVE = 3'h6,
    ST_WBACK = 3'h7
  } state_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_cmd_t;

  typedef struct packed {
    logic [31:0] data;
    logic [3:0] keep;
    logic sof;
    logic eof;
  } tx_beat_t;

endpackage
`default_nettype wire
